// >>> sceh_map.svh
// register address, status bit positions and field-count limits of the link error handler
`ifndef SCEH_MAP_SVH
`define SCEH_MAP_SVH

`define SCEH_ERR_ADDR     16'h0219
`define SCEH_ERR_WIDTH    7
`define SCEH_ERR_RESET    7'h00
`define SCEH_BIT_FRAME    0
`define SCEH_BIT_HEADER   1
`define SCEH_BIT_RW_PAR   2
`define SCEH_BIT_LEN_PAR  3
`define SCEH_BIT_CHKSUM   4
`define SCEH_BIT_TIMEOUT  5
`define SCEH_BIT_RW_DATA  6
`define SCEH_GAP_FIELDS   3
`define SCEH_IDLE_FIELDS  4
`define SCEH_FIELD_CYCLES 2500

`endif

// >>> sceh_pkg.sv
// types shared by the link error handler
`default_nettype none

package sceh_pkg;

	typedef enum logic [2:0] {
		SCEH_STANDBY = 3'b001,
		SCEH_ACTIVE  = 3'b010,
		SCEH_ERROR   = 3'b100
	} sceh_mode_type;

	// one-cycle event strobes from the field decoder
	typedef struct packed {
		logic xfer_start;
		logic xfer_end;
		logic field_done;
		logic is_write;
		logic hdr_bad;
		logic rw_resv_bad;
		logic rw_par_bad;
		logic len_par_bad;
		logic stop_low;
		logic chk_done;
		logic chk_bad;
	} sceh_evt_type;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
		logic        single;
	} sceh_rd_type;

endpackage

`default_nettype wire

// >>> sceh_span_timer.sv
// counts cycles while enabled and flags once the count passes a limit
`timescale 1ns/1ns
`default_nettype none

module sceh_span_timer #(
	parameter int unsigned LIMIT = 7500,
	parameter int unsigned WIDTH = 16
) (
	input  wire logic REF_CLK_I,
	input  wire logic RST_N_I,
	input  wire logic run_i,
	input  wire logic restart_i,
	output var  logic over_o
);

	logic [WIDTH-1:0] count_reg;
	logic [WIDTH-1:0] count_next;
	logic             over_reg;
	logic             over_next;

	always_comb begin
		count_next = count_reg;
		over_next  = over_reg;
		if (restart_i || !run_i) begin
			count_next = '0;
			over_next  = 1'b0;
		end else if (!over_reg) begin
			count_next = count_reg + 1'b1;
			// at or past the limit
			over_next  = (count_reg >= WIDTH'(LIMIT));
		end
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			count_reg <= '0;
			over_reg  <= 1'b0;
		end else begin
			count_reg <= count_next;
			over_reg  <= over_next;
		end
	end

	assign over_o = over_reg;

endmodule // sceh_span_timer

`default_nettype wire

// >>> sceh_link_err.sv
// error detection, status flags and mode control of the single-wire parameter link
//
// How it works
// - seven-bit read-only link error status field
// - reserved R/W bits: flag, keep waiting, drop write
// - gap over three fields: timeout, standby
// - timeout keeps portions already checksum-approved
// - bad write checksum: flag, error mode, discard
// - length parity bad: flag, error mode, discard
// - R/W parity bad: flag, error mode, discard
// - bad header: flag, error mode, discard
// - low stop bit: framing flag, error mode
// - line high over four fields leaves error
// - flags stay set until status read
// - single-byte read clears, multi-byte keeps
`timescale 1ns/1ns
`default_nettype none
`include "sceh_map.svh"

module sceh_link_err
	import sceh_pkg::*;
#(
	parameter int unsigned FIELD_CYCLES = `SCEH_FIELD_CYCLES,
	parameter int unsigned TIMER_WIDTH  = 16
) (
	input  wire logic         REF_CLK_I,
	input  wire logic         RST_N_I,
	input  wire logic         LINE_I,
	input  wire sceh_evt_type EVT_I,
	input  wire sceh_rd_type  RD_I,
	output var  logic [2:0]   MODE_O,
	output var  logic         COMMIT_O,
	output var  logic         DISCARD_O,
	output var  logic [6:0]   ERR_FLAGS_O,
	output var  logic [7:0]   RD_DATA_O,
	output var  logic         RD_ACK_O
);

	localparam int unsigned GAP_LIMIT  = `SCEH_GAP_FIELDS * FIELD_CYCLES;
	localparam int unsigned IDLE_LIMIT = `SCEH_IDLE_FIELDS * FIELD_CYCLES;

	sceh_mode_type                    state_reg;
	sceh_mode_type                    state_next;
	logic [`SCEH_ERR_WIDTH-1:0]       flags_reg;
	logic [`SCEH_ERR_WIDTH-1:0]       flags_next;
	logic [`SCEH_ERR_WIDTH-1:0]       flag_set;
	logic [`SCEH_ERR_WIDTH-1:0]       flag_clr;
	logic                             drop_wr_reg;
	logic                             drop_wr_next;
	logic                             commit_reg;
	logic                             commit_next;
	logic                             discard_reg;
	logic                             discard_next;
	logic [7:0]                       rd_data_reg;
	logic [7:0]                       rd_data_next;
	logic                             rd_ack_reg;
	logic                             rd_ack_next;
	logic                             gap_over;
	logic                             idle_over;
	logic                             live;
	logic                             fatal;
	logic                             rd_hit;

	// gap between fields, only while a transfer is open
	sceh_span_timer #(
		.LIMIT (GAP_LIMIT),
		.WIDTH (TIMER_WIDTH)
	) u_gap_timer (
		.REF_CLK_I (REF_CLK_I),
		.RST_N_I   (RST_N_I),
		.run_i     (state_reg == SCEH_ACTIVE),
		.restart_i (EVT_I.field_done || EVT_I.xfer_start),
		.over_o    (gap_over)
	);

	// idle-high time, only while in error mode
	sceh_span_timer #(
		.LIMIT (IDLE_LIMIT),
		.WIDTH (TIMER_WIDTH)
	) u_idle_timer (
		.REF_CLK_I (REF_CLK_I),
		.RST_N_I   (RST_N_I),
		.run_i     (state_reg == SCEH_ERROR),
		.restart_i (!LINE_I),
		.over_o    (idle_over)
	);

	// error detection and mode transitions
	always_comb begin
		live         = (state_reg != SCEH_ERROR);
		flag_set     = '0;
		state_next   = state_reg;
		drop_wr_next = drop_wr_reg;
		commit_next  = 1'b0;
		discard_next = 1'b0;
		if (live) begin
			flag_set[`SCEH_BIT_FRAME]   = EVT_I.stop_low;
			flag_set[`SCEH_BIT_HEADER]  = EVT_I.hdr_bad;
			flag_set[`SCEH_BIT_RW_PAR]  = EVT_I.rw_par_bad;
			flag_set[`SCEH_BIT_LEN_PAR] = EVT_I.len_par_bad;
			flag_set[`SCEH_BIT_CHKSUM]  = EVT_I.chk_done && EVT_I.chk_bad
				&& EVT_I.is_write;
			flag_set[`SCEH_BIT_RW_DATA] = EVT_I.rw_resv_bad;
		end
		if (state_reg == SCEH_ACTIVE) begin
			flag_set[`SCEH_BIT_TIMEOUT] = gap_over;
		end
		fatal = |flag_set[`SCEH_BIT_CHKSUM:`SCEH_BIT_FRAME];
		case (state_reg)
			SCEH_STANDBY: begin
				if (fatal) begin
					state_next   = SCEH_ERROR;
					discard_next = 1'b1;
				end else if (EVT_I.xfer_start) begin
					state_next   = SCEH_ACTIVE;
					drop_wr_next = EVT_I.rw_resv_bad && EVT_I.is_write;
				end
			end
			SCEH_ACTIVE: begin
				if (fatal) begin
					// failing portion dropped, earlier commits stay
					state_next   = SCEH_ERROR;
					discard_next = 1'b1;
				end else if (gap_over) begin
					state_next = SCEH_STANDBY;
				end else begin
					if (EVT_I.rw_resv_bad && EVT_I.is_write) begin
						drop_wr_next = 1'b1;
					end
					// each approved write portion is committed at once, unless the write is dropped
					commit_next = EVT_I.chk_done && !EVT_I.chk_bad
						&& EVT_I.is_write && !drop_wr_reg
						&& !(EVT_I.rw_resv_bad);
					if (EVT_I.xfer_end) begin
						state_next = SCEH_STANDBY;
					end
				end
			end
			SCEH_ERROR: begin
				if (idle_over) begin
					state_next = SCEH_STANDBY;
				end
			end
			default: begin
				state_next = SCEH_STANDBY;
			end
		endcase
		if (state_next != SCEH_ACTIVE) begin
			drop_wr_next = 1'b0;
		end
	end

	// status register: read and clear
	always_comb begin
		rd_hit       = RD_I.req && (RD_I.addr == `SCEH_ERR_ADDR);
		rd_ack_next  = RD_I.req;
		rd_data_next = rd_data_reg;
		flag_clr     = '0;
		if (RD_I.req) begin
			rd_data_next = rd_hit ? {1'b0, flags_reg} : 8'h00;
		end
		if (rd_hit && RD_I.single) begin
			flag_clr = '1;
		end
		// a new error in the read cycle survives the clear
		flags_next = (flags_reg & ~flag_clr) | flag_set;
	end

	always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg   <= SCEH_STANDBY;
			flags_reg   <= `SCEH_ERR_RESET;
			drop_wr_reg <= 1'b0;
			commit_reg  <= 1'b0;
			discard_reg <= 1'b0;
			rd_data_reg <= 8'h00;
			rd_ack_reg  <= 1'b0;
		end else begin
			state_reg   <= state_next;
			flags_reg   <= flags_next;
			drop_wr_reg <= drop_wr_next;
			commit_reg  <= commit_next;
			discard_reg <= discard_next;
			rd_data_reg <= rd_data_next;
			rd_ack_reg  <= rd_ack_next;
		end
	end

	assign MODE_O      = state_reg;
	assign COMMIT_O    = commit_reg;
	assign DISCARD_O   = discard_reg;
	assign ERR_FLAGS_O = flags_reg;
	assign RD_DATA_O   = rd_data_reg;
	assign RD_ACK_O    = rd_ack_reg;

	frame_err_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg != SCEH_ERROR) && EVT_I.stop_low |=>
		flags_reg[`SCEH_BIT_FRAME] && (state_reg == SCEH_ERROR) && discard_reg)
		else $error("low stop bit did not raise framing error");

	header_err_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg != SCEH_ERROR) && EVT_I.hdr_bad |=>
		flags_reg[`SCEH_BIT_HEADER] && (state_reg == SCEH_ERROR))
		else $error("bad header did not raise header error");

	parity_err_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg != SCEH_ERROR) && (EVT_I.len_par_bad || EVT_I.rw_par_bad) |=>
		(flags_reg[`SCEH_BIT_LEN_PAR] || !$past(EVT_I.len_par_bad))
		&& (flags_reg[`SCEH_BIT_RW_PAR] || !$past(EVT_I.rw_par_bad))
		&& (state_reg == SCEH_ERROR))
		else $error("parity error not reported in its bit");

	chksum_err_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && EVT_I.chk_done && EVT_I.chk_bad && EVT_I.is_write
		|=> flags_reg[`SCEH_BIT_CHKSUM] && !commit_reg && (state_reg == SCEH_ERROR))
		else $error("bad write checksum not handled");

	timeout_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && gap_over && !fatal |=>
		flags_reg[`SCEH_BIT_TIMEOUT] && (state_reg == SCEH_STANDBY))
		else $error("gap timeout did not end transfer");

	rw_data_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && EVT_I.rw_resv_bad && EVT_I.is_write && !fatal
		&& !gap_over && !EVT_I.xfer_end |=>
		flags_reg[`SCEH_BIT_RW_DATA] && (state_reg == SCEH_ACTIVE) && drop_wr_reg)
		else $error("reserved bits error left wrong mode");

	flag_hold_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		!(rd_hit && RD_I.single) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("error flag dropped without a single read");

	read_clear_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		rd_hit && RD_I.single && !(|flag_set) |=> (flags_reg == '0)
		&& (rd_data_reg == {1'b0, $past(flags_reg)}))
		else $error("single read did not clear flags");

	quiet_error_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ERROR) |=> !commit_reg && !discard_reg)
		else $error("register change while in error mode");

	recover_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ERROR) && idle_over |=> (state_reg == SCEH_STANDBY))
		else $error("idle-high recovery missed");

	// a timeout ends the transfer but never nullifies what was committed
	timeout_keep_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && gap_over && !fatal |=>
		!discard_reg)
		else $error("timeout discarded committed data");

	commit_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && !fatal && !gap_over && EVT_I.chk_done
		&& !EVT_I.chk_bad && EVT_I.is_write && !drop_wr_reg && !EVT_I.rw_resv_bad
		|=> commit_reg)
		else $error("approved write portion not committed");

	drop_write_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ACTIVE) && drop_wr_reg |=>
		!commit_reg)
		else $error("write committed after reserved bits error");

	err_entry_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg != SCEH_ERROR) && fatal |=>
		(state_reg == SCEH_ERROR) && discard_reg)
		else $error("fault did not enter error mode");

	error_silent_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ERROR) && !(rd_hit && RD_I.single) |=>
		(flags_reg == $past(flags_reg)))
		else $error("flags changed while in error mode");

	error_stays_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(state_reg == SCEH_ERROR) && !idle_over |=>
		(state_reg == SCEH_ERROR))
		else $error("error mode left before idle time");

	read_ack_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		1'b1 |=>
		(rd_ack_reg == $past(RD_I.req)))
		else $error("read acknowledge out of step");

	read_miss_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		RD_I.req && !rd_hit |=>
		(rd_data_reg == 8'h00) && ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("unmapped read changed data or flags");

	multi_read_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		rd_hit && !RD_I.single |=>
		(rd_data_reg == {1'b0, $past(flags_reg)})
		&& ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
		else $error("multi-byte read cleared flags");

	set_wins_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_N_I)
		(|flag_set) |=>
		((flags_reg & $past(flag_set)) == $past(flag_set)))
		else $error("new error lost in a clearing read");

endmodule // sceh_link_err

`default_nettype wire

// >>> sceh_host_model.sv
// host-side master model: link events, line level and status reads
`timescale 1ns/1ns
`default_nettype none

module sceh_host_model
	import sceh_pkg::*;
(
	input  wire logic         REF_CLK_I,
	output var  sceh_evt_type EVT_O,
	output var  sceh_rd_type  RD_O,
	output var  logic         LINE_O
);
	initial begin
		EVT_O = '0;
		RD_O = '0;
		LINE_O = 1'b1;
	end

	// line low while a field is on the wire, idle high after it
	task automatic ev(input sceh_evt_type e);
		@(negedge REF_CLK_I);
		EVT_O = e;
		LINE_O = 1'b0;
		@(negedge REF_CLK_I);
		EVT_O = '0;
		LINE_O = 1'b1;
	endtask

	task automatic rd(input logic [15:0] a, input logic s);
		@(negedge REF_CLK_I);
		RD_O = '{req: 1'b1, addr: a, single: s};
		@(negedge REF_CLK_I);
		RD_O.req = 1'b0;
	endtask
endmodule // sceh_host_model

`default_nettype wire

// >>> tb.sv
// self-checking testbench of the link error handler
`timescale 1ns/1ns
`default_nettype none
`include "sceh_map.svh"

module tb
	import sceh_pkg::*;
;
	// short field so timeout and recovery fit in a brief run
	localparam int unsigned FC = 10;
	logic         ref_clk;
	logic         rst_n;
	sceh_evt_type evt;
	sceh_rd_type  rd;
	logic         line;
	logic [2:0]   mode;
	logic         commit;
	logic         discard;
	logic [6:0]   flags;
	logic [7:0]   rdata;
	logic         ack;
	int           miscompares;
	int           checked;

	sceh_link_err #(.FIELD_CYCLES(FC)) dut (
		.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .LINE_I(line), .EVT_I(evt), .RD_I(rd),
		.MODE_O(mode), .COMMIT_O(commit), .DISCARD_O(discard), .ERR_FLAGS_O(flags),
		.RD_DATA_O(rdata), .RD_ACK_O(ack));

	sceh_host_model host (.REF_CLK_I(ref_clk), .EVT_O(evt), .RD_O(rd), .LINE_O(line));

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	task automatic conclude;
		if (miscompares == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
		n = 0;
		while (mode !== m && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		chk("mode reached", {5'h00, m}, {5'h00, mode});
		if (mode !== m)
			conclude();
	endtask

	task automatic rd_chk(input logic s, input logic [7:0] exp, input logic [6:0] aft);
		host.rd(`SCEH_ERR_ADDR, s);
		chk("ack", 8'h01, {7'h00, ack});
		chk("read data", exp, rdata);
		chk("flags after read", {1'b0, aft}, {1'b0, flags});
	endtask

	task automatic t_reset;
		chk("mode", {5'h00, SCEH_STANDBY}, {5'h00, mode});
		chk("flags", 8'h00, {1'b0, flags});
	endtask

	task automatic t_resv;
		host.ev(11'h400);
		host.ev(11'h1a0);
		chk("mode", 8'h02, {5'h00, mode});
		chk("flags", 8'h40, {1'b0, flags});
		host.ev(11'h182);
		chk("commit", 8'h00, {7'h00, commit});
		// a bad checksum on a read is no fault
		host.ev(11'h103);
		chk("mode", 8'h02, {5'h00, mode});
		host.ev(11'h300);
		chk("mode", 8'h01, {5'h00, mode});
		host.rd(16'h0218, 1'b1);
		chk("miss data", 8'h00, rdata);
		chk("flags", 8'h40, {1'b0, flags});
		rd_chk(1'b0, 8'h40, 7'h40);
		rd_chk(1'b1, 8'h40, 7'h00);
	endtask

	task automatic t_timeout;
		int n;
		host.ev(11'h400);
		host.ev(11'h182);
		chk("commit", 8'h01, {7'h00, commit});
		wait_mode(SCEH_STANDBY, 60, n);
		chk("timeout not early", 8'h01, {7'h00, n >= 3 * FC - 3});
		chk("flags", 8'h20, {1'b0, flags});
		rd_chk(1'b1, 8'h20, 7'h00);
	endtask

	task automatic t_faults;
		logic [10:0] evs [5] = '{11'h040, 11'h010, 11'h008, 11'h004, 11'h083};
		int          pos [5] = '{1, 2, 3, 0, 4};
		logic [7:0]  f;
		int          n;
		for (int i = 0; i < 5; i++) begin
			f = 8'h01 << pos[i];
			host.ev(11'h400);
			host.ev(evs[i]);
			chk("mode", 8'h04, {5'h00, mode});
			chk("discard", 8'h01, {7'h00, discard});
			chk("flags", f, {1'b0, flags});
			host.ev(11'h082);
			chk("commit in error", 8'h00, {7'h00, commit});
			rd_chk(1'b0, f, f[6:0]);
			wait_mode(SCEH_STANDBY, 80, n);
			chk("recovery not early", 8'h01, {7'h00, n >= 4 * FC - 4});
			rd_chk(1'b1, f, 7'h00);
		end
	endtask

	initial begin
		rst_n = 1'b0;
		miscompares = 0;
		checked = 0;
		repeat (5) @(negedge ref_clk);
		rst_n = 1'b1;
		t_reset();
		t_resv();
		t_timeout();
		t_faults();
		conclude();
	end
endmodule // tb

`default_nettype wire
